//--- drp_pkg.sv
// Package of constants for the sample ROM read port
package drp_pkg;
    localparam int          DRP_REG_ADDR_W   = 5;
    localparam int          DRP_NIB_W        = 4;
    localparam int          DRP_ROM_ADDR_W   = 16;
    localparam int          DRP_ROM_DATA_W   = 8;
    // Register offsets in the nibble register space
    localparam logic [4:0]  DRP_OFF_ADDR0    = 5'h18;
    localparam logic [4:0]  DRP_OFF_ADDR1    = 5'h19;
    localparam logic [4:0]  DRP_OFF_ADDR2    = 5'h1a;
    localparam logic [4:0]  DRP_OFF_ADDR3    = 5'h1b;
    localparam logic [4:0]  DRP_OFF_DATA_LO  = 5'h1c;
    localparam logic [4:0]  DRP_OFF_DATA_HI  = 5'h1d;
    // Reset values (documented as unknown; zero chosen)
    localparam logic [3:0]  DRP_ADDR_RST     = 4'h0;
    localparam logic [7:0]  DRP_DATA_RST     = 8'h00;
    // Data ready time: two system clock periods
    localparam int          DRP_READY_CYC    = 2;
    // Reserved tail of the 56K sample area, not checked by hardware
    localparam logic [15:0] DRP_RSVD_BASE    = 16'hdfc0;
    // Ready counter reset value: zero, so data counts as ready after reset
    localparam logic [1:0]  DRP_LAT_RST      = 2'h0;
endpackage

//--- drp_rom_if.sv
// Interface between the register front end and the sample ROM array
`timescale 1ns/1ps
interface drp_rom_if;
    logic [15:0] addr;
    logic [7:0]  data;
    modport front (output addr, input data);
    modport rom   (input addr, output data);
endinterface

//--- drp_rom.sv
// Sample ROM array with one registered read port
`timescale 1ns/1ps
module drp_rom #(
    parameter int DEPTH = 65536
) (
    input  wire logic clk_in,
    input  wire logic rstn_in,
    drp_rom_if.rom    rom_if
);
    import drp_pkg::*;

    // Array contents stand in for the one-time programmed store
    logic [DRP_ROM_DATA_W-1:0] mem [DEPTH];
    logic [DRP_ROM_DATA_W-1:0] data_q;

    // Default contents: pattern of the low address byte
    initial begin
        for (int i = 0; i < DEPTH; i++) begin
            mem[i] = 8'(i);
        end
    end

    // One byte per address, registered read
    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            data_q <= DRP_DATA_RST;
        end else begin
            data_q <= mem[rom_if.addr];
        end
    end

    assign rom_if.data = data_q;
endmodule

//--- drp_read_port.sv
// Register front end of the sample ROM read port
`timescale 1ns/1ps
module drp_read_port (
    input  wire logic                               clk_in,
    input  wire logic                               rstn_in,
    input  wire logic [drp_pkg::DRP_REG_ADDR_W-1:0] reg_addr_in,
    input  wire logic                               reg_wr_in,
    input  wire logic                               reg_rd_in,
    input  wire logic [drp_pkg::DRP_NIB_W-1:0]      reg_wdata_in,
    input  wire logic                               wdt_enable_in,
    output logic [drp_pkg::DRP_NIB_W-1:0]           reg_rdata_out,
    output logic                                    reg_hit_out,
    output logic                                    data_ready_out,
    output logic                                    wdt_restart_out
);
    import drp_pkg::*;

    // Count of nibble address registers and select slots
    localparam int NUM_NIB = DRP_ROM_ADDR_W / DRP_NIB_W;
    localparam int NUM_SEL = NUM_NIB + 2;
    localparam int SEL_LO  = NUM_NIB;
    localparam int SEL_HI  = NUM_NIB + 1;

    // Usage notes:
    // - address reset values are a choice; software sets the address first
    // - the read strobe latches the nibble, so a read inside the ready time
    //   may return a nibble of the previous byte
    // - reads of address registers return the stored nibble
    // - the reserved tail of the sample area decodes like any other byte
    // - writes to the low data register are ignored
    // - a high data register write stores nothing; it only restarts the watchdog when the option is on
    // - the watchdog option is a level from this clock domain, not synchronised
    // - unmapped offsets read as zero and flag no hit
    // - strobes may come on back-to-back edges
    // - a write and a read in one cycle are both honoured
    // - the array output register resets with the rest of the block
    // - ready falls on the edge after an address write
    //   and stays low for the whole ready time
    // - nothing here alters the address except an address write or reset

    // Offset decode
    logic [NUM_SEL-1:0]        sel_vec;
    logic                      sel_addr     [NUM_NIB];
    logic                      sel_lo;
    logic                      sel_hi;

    // Address register bank
    logic [DRP_NIB_W-1:0]      addr_q       [NUM_NIB];
    logic [DRP_NIB_W-1:0]      addr_d       [NUM_NIB];
    logic [DRP_NIB_W-1:0]      addr_rd_term [NUM_NIB];
    wire  [NUM_NIB-1:0]        wr_addr_vec;
    logic [DRP_NIB_W-1:0]      addr_rd_mux;
    logic                      addr_wr;
    logic                      any_addr_sel;
    logic                      any_data_sel;

    // Sample ROM address and returned byte
    wire  [DRP_ROM_ADDR_W-1:0] rom_addr;
    logic [DRP_ROM_DATA_W-1:0] rom_byte;
    logic [DRP_NIB_W-1:0]      byte_lo;
    logic [DRP_NIB_W-1:0]      byte_hi;

    // Read data path
    logic [DRP_NIB_W-1:0]      data_rd_mux;
    logic [DRP_NIB_W-1:0]      rdata_d;
    logic [DRP_NIB_W-1:0]      rdata_q;

    // Data ready counter
    logic [1:0]                lat_dec;
    logic [1:0]                lat_d;
    logic [1:0]                lat_q;
    logic                      lat_busy;

    // Watchdog restart pulse
    logic                      wr_hi;
    logic                      wdt_d;
    logic                      wdt_q;

    // Link to the byte array
    drp_rom_if rom_bus ();

    // Offset decode into one select per register
    // The offsets never overlap, so the chain order is free
    always_comb begin
        sel_vec = '0;
        if (reg_addr_in == DRP_OFF_ADDR0) begin
            sel_vec[0] = 1'b1;
        end else if (reg_addr_in == DRP_OFF_ADDR1) begin
            sel_vec[1] = 1'b1;
        end else if (reg_addr_in == DRP_OFF_ADDR2) begin
            sel_vec[2] = 1'b1;
        end else if (reg_addr_in == DRP_OFF_ADDR3) begin
            sel_vec[3] = 1'b1;
        end else if (reg_addr_in == DRP_OFF_DATA_LO) begin
            sel_vec[SEL_LO] = 1'b1;
        end else if (reg_addr_in == DRP_OFF_DATA_HI) begin
            sel_vec[SEL_HI] = 1'b1;
        end
    end

    // Data register selects
    assign sel_lo       = sel_vec[SEL_LO];
    assign sel_hi       = sel_vec[SEL_HI];
    assign any_data_sel = sel_lo || sel_hi;

    // Any address register hit or written
    assign any_addr_sel = |sel_vec[NUM_NIB-1:0];
    assign addr_wr      = |wr_addr_vec;

    // Mapped offset flag for the bus side
    // Combinational so the bus can steer on the same edge
    assign reg_hit_out  = any_addr_sel || any_data_sel;

    // Per-nibble select, write enable, next value, readback and register
    // One loop keeps the four nibbles identical in timing
    for (genvar n = 0; n < NUM_NIB; n++) begin : g_addr
        assign sel_addr[n]     = sel_vec[n];
        assign wr_addr_vec[n]  = reg_wr_in && sel_addr[n];
        // Only a write changes the nibble; data reads leave it alone
        assign addr_d[n]       = wr_addr_vec[n] ? reg_wdata_in : addr_q[n];
        assign addr_rd_term[n] = sel_addr[n] ? addr_q[n] : '0;
        // Nibble n sits at bits 4n+3..4n of the byte address
        assign rom_addr[n*DRP_NIB_W +: DRP_NIB_W] = addr_q[n];

        // Address nibble register
        always_ff @(posedge clk_in) begin
            if (!rstn_in) begin
                addr_q[n] <= DRP_ADDR_RST;
            end else begin
                addr_q[n] <= addr_d[n];
            end
        end
    end

    // Readback of the selected address nibble; selects are one-hot
    assign addr_rd_mux = addr_rd_term[0]
                         | addr_rd_term[1]
                         | addr_rd_term[2]
                         | addr_rd_term[3];

    // Byte address toward the array; no check on the reserved tail
    assign rom_bus.addr = rom_addr;

    // Byte array, one byte per address, registered read
    // Behind an interface so the array can be swapped for a macro
    drp_rom u_rom (
        .clk_in  (clk_in),
        .rstn_in (rstn_in),
        .rom_if  (rom_bus)
    );

    // Split of the addressed byte into its two nibbles
    assign rom_byte = rom_bus.data;
    assign byte_lo  = rom_byte[3:0];
    assign byte_hi  = rom_byte[7:4];

    // Data nibble for a data register read
    assign data_rd_mux = sel_hi ? byte_hi : byte_lo;

    // Read source: data nibble, address nibble, or zero when unmapped
    // Unmapped offsets fall through to the address readback, which is zero
    assign rdata_d = any_data_sel ? data_rd_mux : addr_rd_mux;

    // Registered read data, held until the next read strobe
    // Holding it lets software read at its own pace after the strobe
    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            rdata_q <= '0;
        end else if (reg_rd_in) begin
            rdata_q <= rdata_d;
        end
    end
    assign reg_rdata_out = rdata_q;

    // Ready counter: an address write reloads it, then it counts down
    // The array answers one edge after the address settles; the count
    // allows the full ready time so software timing stays the same
    assign lat_busy = (lat_q != 2'h0);
    assign lat_dec  = lat_q - 2'h1;
    assign lat_d    = addr_wr  ? 2'(DRP_READY_CYC)
                    : lat_busy ? lat_dec
                    : lat_q;

    // Ready time counter register
    // Reset leaves it at zero: the reset address byte is ready at once
    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            lat_q <= DRP_LAT_RST;
        end else begin
            lat_q <= lat_d;
        end
    end

    // Ready once the count has run out
    assign data_ready_out = !lat_busy;

    // Restart request: high data write with the watchdog option on
    assign wr_hi = reg_wr_in && sel_hi;
    assign wdt_d = wr_hi && wdt_enable_in;

    // Restart pulse toward the watchdog, high one cycle per high data write made with the option on
    // Registered so the pulse is clean; back-to-back writes keep it high
    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            wdt_q <= 1'b0;
        end else begin
            wdt_q <= wdt_d;
        end
    end
    assign wdt_restart_out = wdt_q;
endmodule

//--- drp_read_port_checker.sv
// Concurrent checks on the ports of the sample ROM read port
`timescale 1ns/1ps
module drp_checker (
    input wire logic       clk_in,
    input wire logic       rstn_in,
    input wire logic [4:0] reg_addr_in,
    input wire logic       reg_wr_in,
    input wire logic       reg_rd_in,
    input wire logic [3:0] reg_wdata_in,
    input wire logic       wdt_enable_in,
    input wire logic [3:0] reg_rdata_out,
    input wire logic       reg_hit_out,
    input wire logic       data_ready_out,
    input wire logic       wdt_restart_out
);
    logic [15:0] addr_q;
    // Decoded accesses
    wire wr_a  = reg_wr_in && reg_addr_in[4:2] == 3'b110;
    wire wr_hi = reg_wr_in && reg_addr_in == 5'h1d;
    wire rd_lo = reg_rd_in && reg_addr_in == 5'h1c && data_ready_out;
    wire rd_hi = reg_rd_in && reg_addr_in == 5'h1d && data_ready_out;
    default clocking @(posedge clk_in); endclocking
    default disable iff (!rstn_in);
    // Shadow address, ROM holds its own low address byte
    always_ff @(posedge clk_in)
        if (!rstn_in) addr_q <= 16'h0000;
        else if (wr_a) addr_q[reg_addr_in[1:0]*4 +: 4] <= reg_wdata_in;
    // Address write followed by two quiet cycles
    sequence s_aw; wr_a ##1 !wr_a [*2]; endsequence
    property p_hit; reg_hit_out == (reg_addr_in >= 5'h18 && reg_addr_in <= 5'h1d); endproperty
    property p_lo; rd_lo |=> reg_rdata_out == addr_q[3:0]; endproperty
    property p_hi; rd_hi |=> reg_rdata_out == addr_q[7:4]; endproperty
    property p_rdy; s_aw |-> ##1 data_ready_out; endproperty
    property p_wdt; wr_hi |=> wdt_restart_out == $past(wdt_enable_in); endproperty
    property p_wdt_only; !wr_hi |=> !wdt_restart_out; endproperty
    property p_hold; !reg_rd_in |=> $stable(reg_rdata_out); endproperty
    a_hit: assert property (p_hit) else $error("hit decode wrong");
    a_lo: assert property (p_lo) else $error("low nibble wrong");
    a_hi: assert property (p_hi) else $error("high nibble wrong");
    a_rdy: assert property (p_rdy) else $error("data not ready");
    a_wdt: assert property (p_wdt) else $error("restart pulse wrong");
    a_wdt_only: assert property (p_wdt_only) else $error("stray restart");
    a_hold: assert property (p_hold) else $error("read data moved");
endmodule
bind drp_read_port drp_checker u_drp_checker (.clk_in(clk_in), .rstn_in(rstn_in),
    .reg_addr_in(reg_addr_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
    .reg_wdata_in(reg_wdata_in), .wdt_enable_in(wdt_enable_in), .reg_rdata_out(reg_rdata_out),
    .reg_hit_out(reg_hit_out), .data_ready_out(data_ready_out), .wdt_restart_out(wdt_restart_out));

//--- testbench.sv
// Self-checking testbench for the sample ROM read port
`timescale 1ns/1ps
module testbench;
    logic        clk_in = 1'b0;
    logic        rstn_in = 1'b0;
    logic [4:0]  reg_addr_in = 5'h00;
    logic        reg_wr_in = 1'b0;
    logic        reg_rd_in = 1'b0;
    logic [3:0]  reg_wdata_in = 4'h0;
    logic        wdt_enable_in = 1'b0;
    logic [3:0]  reg_rdata_out;
    logic        reg_hit_out;
    logic        data_ready_out;
    logic        wdt_restart_out;
    logic [3:0]  exp_q[$];
    logic        pend = 1'b0;
    logic        wpend = 1'b0;
    logic        apend = 1'b0;
    logic [15:0] a;
    int          mismatches = 0;
    int          tests_run = 0;
    drp_read_port u_drp_read_port (.clk_in(clk_in), .rstn_in(rstn_in), .reg_addr_in(reg_addr_in),
        .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_wdata_in(reg_wdata_in),
        .wdt_enable_in(wdt_enable_in), .reg_rdata_out(reg_rdata_out), .reg_hit_out(reg_hit_out),
        .data_ready_out(data_ready_out), .wdt_restart_out(wdt_restart_out));
    initial begin
        forever #5 clk_in = ~clk_in;
    end
    task check(input logic [3:0] s, input logic [3:0] e);
        tests_run++;
        if (s !== e) begin
            mismatches++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    // One register access; a read notes the nibble it expects
    task op(input logic w, input logic [4:0] ad, input logic [3:0] d);
        @(posedge clk_in);
        reg_addr_in <= ad;
        reg_wdata_in <= d;
        reg_wr_in <= w;
        reg_rd_in <= !w;
        if (!w) exp_q.push_back(d);
        @(posedge clk_in);
        reg_wr_in <= 1'b0;
        reg_rd_in <= 1'b0;
    endtask
    // Oldest note against each read answer
    always @(posedge clk_in) begin
        if (pend) check(reg_rdata_out, exp_q.pop_front());
        if (rstn_in) check(4'(wdt_restart_out), 4'(wpend));
        if (rstn_in) check(4'(reg_hit_out), 4'(reg_addr_in inside {[5'h18:5'h1d]}));
        if (apend) check(4'(data_ready_out), 4'h0);
        if (reg_rd_in && reg_addr_in[4:2] == 3'b111) check(4'(data_ready_out), 4'h1);
        pend <= reg_rd_in;
        wpend <= rstn_in && reg_wr_in && reg_addr_in == 5'h1d && wdt_enable_in;
        apend <= rstn_in && reg_wr_in && reg_addr_in[4:2] == 3'b110;
    end
    task complete_run;
        $display("comparisons %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    // Hang guard
    initial begin
        #100000;
        mismatches++;
        complete_run();
    end
    initial begin
        void'($urandom(51));
        repeat (16) @(posedge clk_in);
        rstn_in <= 1'b1;
        for (int i = 0; i < 24; i++) begin
            a = (i == 0) ? 16'hdfc0 : 16'($urandom);
            wdt_enable_in <= 1'($urandom);
            for (int k = 0; k < 4; k++) op(1'b1, 5'h18 + 5'(k), a[k*4 +: 4]);
            @(posedge clk_in);
            op(1'b0, 5'h1c, a[3:0]);
            op(1'b0, 5'h1d, a[7:4]);
            op(1'b1, 5'h1c, ~a[3:0]);
            op(1'b0, 5'h1c, a[3:0]);
            op(1'b0, 5'h18 + 5'(i % 4), a[(i % 4)*4 +: 4]);
            op(1'b0, 5'h17, 4'h0);
            op(1'b1, 5'h1d, 4'(i));
            $display("test %0d done", i);
        end
        // Reset in mid-run brings the address back to zero
        rstn_in <= 1'b0;
        repeat (2) @(posedge clk_in);
        rstn_in <= 1'b1;
        op(1'b0, 5'h1d, 4'h0);
        repeat (2) @(posedge clk_in);
        $display("test reset done");
        complete_run();
    end
endmodule
